// file: hdl/serial_pkg.sv
// Constants, layouts and state record of the asynchronous serial block
// Function
// - Bit rate is crystal over 32 times divisor
// - Zero divisor stops the baud generator
// - Divisor split high five, low eight bits
// - Top high bits are test; bit five zero
// - Loop-back feeds transmitter into receiver internally
// - Open-drain option makes driven pins open-drain
// - Frame: start, eight or nine data, stop
// - Wake on quiet line or address mark
// - Short counts after start, long after stop
// - Parity generated and checked when enabled
// - Even or odd parity sense
// - Empty buffer flag with enable requests interrupt
// - Done flag with enable requests interrupt
// - Full or overrun with enable requests interrupt
// - Quiet flag with enable requests interrupt
// - Transmitter starts a frame only while enabled; a frame in progress still runs to its end
// - Receiver works only while enabled
// - Quiet detection needs a start bit before each quiet period
// - Transmit flags clear by status read, data write
// - Overrun set on early arrival, cleared by sequence
// - Sleep inhibits receive interrupts and quiet flag
// - Ninth bits held in high data register
package serial_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam int         ADDR_W        = 9;
  localparam logic [6:0] OFS_BAUD_HIGH = 7'h70;
  localparam logic [6:0] OFS_BAUD_LOW  = 7'h71;
  localparam logic [6:0] OFS_CTRL_ONE  = 7'h72;
  localparam logic [6:0] OFS_CTRL_TWO  = 7'h73;
  localparam logic [6:0] OFS_FLAGS     = 7'h74;
  localparam logic [6:0] OFS_ACTIVE    = 7'h75;
  localparam logic [6:0] OFS_DATA_HIGH = 7'h76;
  localparam logic [6:0] OFS_DATA_LOW  = 7'h77;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ==========================================================
  // Reset values and field positions
  localparam logic [12:0] BAUD_RST   = 13'h0004;
  localparam logic [7:0]  FLAGS_RST  = 8'hc0;
  localparam int          RX9_POS    = 7;
  localparam int          TX9_POS    = 6;
  localparam int          F_TBE      = 7;
  localparam int          F_TDN      = 6;
  localparam int          F_RXF      = 5;
  localparam int          F_QUIET    = 4;
  localparam int          F_OVR      = 3;
  localparam int          F_NOISE    = 2;
  localparam int          F_FRAME    = 1;
  localparam int          F_PAR      = 0;
  localparam logic [7:0]  TX_MASK    = 8'hc0;
  localparam logic [7:0]  RX_MASK    = 8'h3f;

  // ==========================================================
  // Frame timing in sample ticks and bits
  localparam logic [3:0] BITS_8   = 4'ha;
  localparam logic [3:0] BITS_9   = 4'hb;
  localparam logic [3:0] SMP_A    = 4'h7;
  localparam logic [3:0] SMP_B    = 4'h8;
  localparam logic [3:0] SMP_C    = 4'h9;
  localparam logic [3:0] PH_LAST  = 4'hf;

  // ==========================================================
  // Control register layouts
  typedef struct packed {
    logic loopback_select;
    logic serial_open_drain;
    logic gap;
    logic nine_bit_fmt;
    logic wake_by_mark;
    logic quiet_line_kind;
    logic parity_on;
    logic parity_odd_sel;
  } ctrl1_t;

  typedef struct packed {
    logic tx_empty_irq_en;
    logic tx_done_irq_en;
    logic rx_full_irq_en;
    logic quiet_irq_en;
    logic tx_on;
    logic rx_on;
    logic rx_sleep;
    logic send_break;
  } ctrl2_t;

  typedef struct packed {
    logic [1:0]  btest;
    logic [12:0] baud_divisor;
    ctrl1_t      c1;
    ctrl2_t      c2;
    logic [8:0]  tx_data;
    logic [7:0]  fl;
    logic [7:0]  arm;
    logic        tx_busy;
    logic [10:0] tx_sh;
    logic [3:0]  tx_cnt;
    logic [3:0]  tx_ph;
    logic        tx_line;
    logic        rx_busy;
    logic [3:0]  rx_ph;
    logic [3:0]  rx_idx;
    logic [8:0]  rx_sh;
    logic [1:0]  rx_smp;
    logic        rx_noise;
    logic [8:0]  rx_data;
    logic [3:0]  ones;
    logic        quiet_arm;
    logic [13:0] div;
    logic        tick;
    logic        rd_pend;
    logic        wr_pend;
    logic [6:0]  ri;
    logic [7:0]  rdata;
    logic        hready;
    logic        txd_out;
    logic        txd_oe;
    logic        irq;
  } state_t;

endpackage : serial_pkg

// file: hdl/serial_port.sv
// Asynchronous serial transmitter, receiver, baud divider and AHB-Lite slave
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module serial_port
  import serial_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              rxd_in,
  output logic                   txd_out,
  output logic                   txd_oe,
  output logic                   irq
);

  // ==========================================================
  // Helpers
  function automatic logic frame_par(input logic [8:0] d, input logic nine, input logic odd);
    frame_par = (nine ? ^d[7:0] : ^d[6:0]) ^ odd;
  endfunction : frame_par

  function automatic logic [3:0] inc_sat(input logic [3:0] x);
    inc_sat = (x == 4'hf) ? x : x + 4'h1;
  endfunction : inc_sat

  state_t      s;
  state_t      n;
  logic [13:0] lim;
  logic [8:0]  w;
  logic [8:0]  dat;
  logic        rxl;
  logic        nine;
  logic [3:0]  last;
  logic        v;
  logic        unan;
  logic        perr;
  logic        take;

  assign hrdata    = {24'h0, s.rdata};
  assign hreadyout = s.hready;
  assign hresp     = 1'b0;
  assign txd_out   = s.txd_out;
  assign txd_oe    = s.txd_oe;
  assign irq       = s.irq;

  // ==========================================================
  // Next state
  always_comb begin
    n    = s;
    nine = s.c1.nine_bit_fmt;
    last = (nine ? BITS_9 : BITS_8) - 4'h1;
    rxl  = s.c1.loopback_select ? s.tx_line : rxd_in;
    w    = s.tx_data;
    dat  = nine ? s.rx_sh : {1'b0, s.rx_sh[8:1]};
    v    = 1'b0;
    unan = 1'b1;
    perr = 1'b0;
    take = 1'b0;
    lim  = {s.baud_divisor, 1'b0} - 14'h1;

    // Baud generator, one sample tick every two times divisor clocks
    n.tick = 1'b0;
    if (s.baud_divisor == 13'h0) begin
      n.div = 14'h0;
    end else if (s.div >= lim) begin
      n.div  = 14'h0;
      n.tick = 1'b1;
    end else begin
      n.div = s.div + 14'h1;
    end

    // Bus data phase of a write
    if (s.wr_pend) begin
      case (s.ri)
        OFS_BAUD_HIGH: begin
          n.btest              = hwdata[7:6];
          n.baud_divisor[12:8] = hwdata[4:0];
        end
        OFS_BAUD_LOW:  n.baud_divisor[7:0] = hwdata[7:0];
        OFS_CTRL_ONE: begin
          n.c1     = ctrl1_t'(hwdata[7:0]);
          n.c1.gap = 1'b0;
        end
        OFS_CTRL_TWO:  n.c2 = ctrl2_t'(hwdata[7:0]);
        OFS_DATA_HIGH: n.tx_data[8] = hwdata[TX9_POS];
        OFS_DATA_LOW: begin
          n.tx_data[7:0] = hwdata[7:0];
          n.fl           = s.fl & ~(s.arm & TX_MASK);
          n.arm          = s.arm & ~TX_MASK;
        end
        default: ;
      endcase
    end

    // Bus read answer, one wait state
    n.rdata  = 8'h0;
    n.hready = 1'b1;
    if (s.rd_pend) begin
      case (s.ri)
        OFS_BAUD_HIGH: n.rdata = {s.btest, 1'b0, s.baud_divisor[12:8]};
        OFS_BAUD_LOW:  n.rdata = s.baud_divisor[7:0];
        OFS_CTRL_ONE:  n.rdata = s.c1;
        OFS_CTRL_TWO:  n.rdata = s.c2;
        OFS_FLAGS: begin
          n.rdata = s.fl;
          n.arm   = s.arm | s.fl;
        end
        OFS_ACTIVE:    n.rdata = {7'h0, s.rx_busy};
        OFS_DATA_HIGH: n.rdata = {s.rx_data[8], s.tx_data[8], 6'h0};
        OFS_DATA_LOW: begin
          n.rdata = s.rx_data[7:0];
          n.fl    = s.fl & ~(s.arm & RX_MASK);
          n.arm   = s.arm & ~RX_MASK;
        end
        default: ;
      endcase
    end

    // Bus address phase
    n.rd_pend = 1'b0;
    n.wr_pend = 1'b0;
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      n.ri      = haddr[ADDR_W-1:2];
      n.rd_pend = !hwrite;
      n.wr_pend = hwrite;
      n.hready  = hwrite;
    end

    // Transmitter
    if (s.tick) begin
      if (s.tx_busy) begin
        n.tx_ph = s.tx_ph + 4'h1;
        if (s.tx_ph == PH_LAST) begin
          n.tx_sh  = {1'b1, s.tx_sh[10:1]};
          n.tx_cnt = s.tx_cnt - 4'h1;
          if (s.tx_cnt == 4'h1) begin
            n.tx_busy = 1'b0;
          end
        end
      end else if (s.c2.tx_on && !n.fl[F_TBE]) begin
        // Take the character being written this cycle, not the stale one
        w = n.tx_data;
        if (s.c1.parity_on) begin
          if (nine) begin
            w[8] = frame_par(n.tx_data, 1'b1, s.c1.parity_odd_sel);
          end else begin
            w[7] = frame_par(n.tx_data, 1'b0, s.c1.parity_odd_sel);
          end
        end
        n.tx_sh     = nine ? {1'b1, w, 1'b0} : {2'h3, w[7:0], 1'b0};
        n.tx_cnt    = nine ? BITS_9 : BITS_8;
        n.tx_busy   = 1'b1;
        n.tx_ph     = 4'h0;
        n.fl[F_TBE] = 1'b1;
      end
    end
    if (!n.tx_busy && n.fl[F_TBE]) begin
      n.fl[F_TDN] = 1'b1;
    end
    n.tx_line = n.tx_busy ? n.tx_sh[0] : !(n.c2.send_break && n.c2.tx_on);

    // Receiver
    if (!s.c2.rx_on) begin
      n.rx_busy = 1'b0;
      n.rx_ph   = 4'h0;
    end else if (s.tick) begin
      n.rx_ph = s.rx_ph + 4'h1;
      if (!s.rx_busy) begin
        if (!rxl) begin
          n.rx_busy   = 1'b1;
          n.rx_ph     = 4'h1;
          n.rx_idx    = 4'h0;
          n.rx_noise  = 1'b0;
          n.quiet_arm = 1'b1;
          if (s.c1.quiet_line_kind) begin
            n.ones = 4'h0;
          end
        end else if (s.rx_ph == PH_LAST) begin
          n.ones = inc_sat(s.ones);
        end
      end else begin
        if (s.rx_ph == SMP_A || s.rx_ph == SMP_B) begin
          n.rx_smp = {s.rx_smp[0], rxl};
        end
        if (s.rx_ph == SMP_C) begin
          v          = (s.rx_smp[1] & s.rx_smp[0]) | (rxl & (s.rx_smp[1] | s.rx_smp[0]));
          unan       = (&{s.rx_smp, rxl}) | !(|{s.rx_smp, rxl});
          n.rx_noise = s.rx_noise | !unan;
          n.rx_idx   = s.rx_idx + 4'h1;
          if (s.rx_idx == 4'h0) begin
            n.rx_busy = !v;
          end else if (s.rx_idx < last) begin
            n.rx_sh = {v, s.rx_sh[8:1]};
            if (!s.c1.quiet_line_kind) begin
              n.ones = v ? inc_sat(s.ones) : 4'h0;
            end
          end else begin
            n.rx_busy = 1'b0;
            n.ones    = (v && !s.c1.quiet_line_kind) ? inc_sat(s.ones) : 4'h0;
            perr      = s.c1.parity_on
                        && (frame_par(dat, nine, s.c1.parity_odd_sel) != (nine ? dat[8] : dat[7]));
            take      = !s.c2.rx_sleep || (s.c1.wake_by_mark && s.rx_sh[8]);
            if (take) begin
              n.c2.rx_sleep = 1'b0;
              if (n.fl[F_RXF]) begin
                n.fl[F_OVR] = 1'b1;
              end else begin
                n.rx_data     = dat;
                n.fl[F_RXF]   = 1'b1;
                n.fl[F_NOISE] = s.fl[F_NOISE] | n.rx_noise;
                n.fl[F_FRAME] = s.fl[F_FRAME] | !v;
                n.fl[F_PAR]   = s.fl[F_PAR] | perr;
              end
            end
          end
        end
      end
    end

    // Quiet line detection and wakeup
    if (s.c2.rx_on && !n.rx_busy && n.quiet_arm && n.ones >= (nine ? BITS_9 : BITS_8)) begin
      n.quiet_arm = 1'b0;
      if (!n.c2.rx_sleep) begin
        n.fl[F_QUIET] = 1'b1;
      end else if (!s.c1.wake_by_mark) begin
        n.c2.rx_sleep = 1'b0;
      end
    end

    // Pins and interrupt request
    n.txd_oe  = s.c2.tx_on && !s.c1.loopback_select
                && (!s.c1.serial_open_drain || !s.tx_line);
    n.txd_out = s.tx_line && !s.c1.serial_open_drain;
    n.irq     = (s.c2.tx_empty_irq_en && s.fl[F_TBE])
                || (s.c2.tx_done_irq_en && s.fl[F_TDN])
                || (s.c2.rx_full_irq_en && !s.c2.rx_sleep
                    && (s.fl[F_RXF] || s.fl[F_OVR]))
                || (s.c2.quiet_irq_en && s.fl[F_QUIET] && !s.c2.rx_sleep);
  end

  // ==========================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s              <= '0;
      s.baud_divisor <= BAUD_RST;
      s.fl           <= FLAGS_RST;
      s.tx_line      <= 1'b1;
      s.hready       <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence tick_pair_s;
    !s.tick ##1 s.tick;
  endsequence

  sequence rd_wait_s;
    !hreadyout ##1 hreadyout;
  endsequence

  baud_period_a: assert property ((s.tick && s.baud_divisor == 13'h1 && !s.wr_pend) |=> tick_pair_s)
    else $error("divisor one does not tick every two clocks");
  baud_stop_a: assert property ((s.baud_divisor == 13'h0) |=> !s.tick)
    else $error("tick produced with zero divisor");
  read_wait_a: assert property ((hsel && hready && htrans == HTRANS_NONSEQ && !hwrite) |=> rd_wait_s)
    else $error("read answer not after one wait state");
  high_gap_a: assert property ((s.rd_pend && s.ri == OFS_BAUD_HIGH) |=> hrdata[5] == 1'b0)
    else $error("unused divisor bit read as one");
  loop_pin_a: assert property ($past(s.c1.loopback_select) |-> !txd_oe)
    else $error("pin driven in loop-back");
  open_drain_a: assert property ((txd_oe && $past(s.c1.serial_open_drain)) |-> !txd_out)
    else $error("open-drain pin driven high");
  idle_high_a: assert property (($past(s.c2.tx_on && !s.tx_busy && !s.c2.send_break)
      && $past(!s.c1.serial_open_drain && !s.c1.loopback_select)) |-> (txd_out && txd_oe))
    else $error("idle line not high");
  irq_empty_a: assert property ((s.c2.tx_empty_irq_en && s.fl[F_TBE]) |=> irq)
    else $error("missing empty interrupt");
  irq_done_a: assert property ((s.c2.tx_done_irq_en && s.fl[F_TDN]) |=> irq)
    else $error("missing done interrupt");
  irq_full_a: assert property ((s.c2.rx_full_irq_en && !s.c2.rx_sleep
      && (s.fl[F_RXF] || s.fl[F_OVR])) |=> irq)
    else $error("missing receive interrupt");
  irq_quiet_a: assert property ((s.c2.quiet_irq_en && s.fl[F_QUIET] && !s.c2.rx_sleep) |=> irq)
    else $error("missing quiet interrupt");
  tx_off_a: assert property ((!s.c2.tx_on && !s.tx_busy) |=> !s.tx_busy)
    else $error("transmit started while disabled");
  rx_off_a: assert property (!s.c2.rx_on |=> !s.rx_busy)
    else $error("receiver busy while disabled");
  empty_clr_a: assert property ($fell(s.fl[F_TBE]) |-> $past(s.arm[F_TBE] && s.wr_pend
      && s.ri == OFS_DATA_LOW))
    else $error("empty flag cleared without sequence");
  overrun_a: assert property ($rose(s.fl[F_OVR]) |-> $past(s.fl[F_RXF]))
    else $error("overrun without full buffer");
  sleep_quiet_a: assert property ($rose(s.fl[F_QUIET]) |-> !$past(s.c2.rx_sleep))
    else $error("quiet flag set while asleep");

endmodule : serial_port
`default_nettype wire

// file: test/serial_remote.sv
// Remote serial station model on the transmit and receive lines
`timescale 1ns/1ns
`default_nettype none
module serial_remote (
  input  wire logic hclk,
  input  wire logic txd_out,
  input  wire logic txd_oe,
  output logic      rxd_in
);
  int         bit_clks = 32;
  int         nbits    = 8;
  int         frames   = 0;
  logic [9:0] frm;
  wire        line;
  // ==========================================================
  // Released pin floats high through the pull-up
  assign line = txd_oe ? txd_out : 1'b1;
  initial rxd_in = 1'b1;
  // ==========================================================
  // Capture: start, data bits first to last, stop
  always begin : capture
    do @(posedge hclk); while (line !== 1'b0);
    repeat (bit_clks / 2) @(posedge hclk);
    for (int i = 0; i <= nbits; i++) begin
      repeat (bit_clks) @(posedge hclk);
      frm[i] = line;
    end
    frames++;
  end
  // ==========================================================
  // Send one frame, idle high afterwards
  task automatic send(input logic [8:0] d);
    @(posedge hclk);
    rxd_in <= 1'b0;
    repeat (bit_clks) @(posedge hclk);
    for (int i = 0; i < nbits; i++) begin
      rxd_in <= d[i];
      repeat (bit_clks) @(posedge hclk);
    end
    rxd_in <= 1'b1;
    repeat (bit_clks) @(posedge hclk);
  endtask : send
endmodule : serial_remote
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the serial block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import serial_pkg::*;
  typedef struct packed {
    logic       w;
    logic [6:0] idx;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;
  logic              hclk    = 1'b0;
  logic              hresetn = 1'b0;
  logic              hsel    = 1'b0;
  logic              hwrite  = 1'b0;
  logic [ADDR_W-1:0] haddr   = '0;
  logic [1:0]        htrans  = 2'h0;
  logic [2:0]        hsize   = 3'h2;
  logic [31:0]       hwdata  = 32'h0;
  logic [31:0]       hrdata;
  logic              hreadyout;
  logic              hresp;
  logic              rxd_in;
  logic              txd_out;
  logic              txd_oe;
  logic              irq;
  int                failures    = 0;
  int                check_count = 0;
  int                n0;
  logic [7:0]        q;
  logic [7:0]        ie [3] = '{8'h80, 8'h40, 8'h10};
  row_t              rows [11] = '{
    '{1'b0, OFS_BAUD_HIGH, 8'h00, 8'h00}, '{1'b0, OFS_BAUD_LOW, 8'h00, 8'h04},
    '{1'b0, OFS_CTRL_ONE, 8'h00, 8'h00}, '{1'b0, OFS_CTRL_TWO, 8'h00, 8'h00},
    '{1'b0, OFS_FLAGS, 8'h00, 8'hc0}, '{1'b0, OFS_ACTIVE, 8'h00, 8'h00},
    '{1'b1, OFS_BAUD_HIGH, 8'h3f, 8'h1f}, '{1'b1, OFS_BAUD_HIGH, 8'h00, 8'h00},
    '{1'b1, OFS_CTRL_ONE, 8'h20, 8'h00}, '{1'b1, 7'h78, 8'h55, 8'h00},
    '{1'b1, OFS_BAUD_LOW, 8'h01, 8'h01}};

  always #4 hclk = ~hclk;

  serial_port serial_port_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd_in(rxd_in),
    .txd_out(txd_out), .txd_oe(txd_oe), .irq(irq));
  serial_remote serial_remote_inst (.hclk(hclk), .txd_out(txd_out), .txd_oe(txd_oe),
    .rxd_in(rxd_in));

  // ==========================================================
  // Report, compare and bus tasks
  task automatic test_done();
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  task automatic hang(input string msg);
    failures++;
    $display("BAD %0t %s", $time, msg);
    test_done();
  endtask : hang

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) hang("bus hang");
  endtask : wait_ready

  task automatic xfer(input logic w, input logic [6:0] idx, input logic [7:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {idx, 2'b00};
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_ready();
    q = hrdata[7:0];
  endtask : xfer

  task automatic rd_chk(input logic [6:0] idx, input logic [7:0] e, input string msg);
    xfer(1'b0, idx, 8'h00);
    chk(q, e, msg);
  endtask : rd_chk

  task automatic poll(input int b);
    q = 8'h00;
    for (int k = 0; k < 200 && q[b] !== 1'b1; k++) xfer(1'b0, OFS_FLAGS, 8'h00);
    if (q[b] !== 1'b1) hang("flag wait");
  endtask : poll

  task automatic wait_frame();
    int k;
    for (k = 0; k < 2000 && serial_remote_inst.frames == n0; k++) @(posedge hclk);
    if (k == 2000) hang("frame wait");
  endtask : wait_frame

  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) xfer(1'b1, rows[i].idx, rows[i].d);
      rd_chk(rows[i].idx, rows[i].e, "register value");
      chk({7'h0, hresp}, 8'h00, "bus response");
    end
    foreach (ie[i]) begin
      xfer(1'b1, OFS_CTRL_TWO, ie[i]);
      repeat (2) @(posedge hclk);
      chk({7'h0, irq}, (i < 2) ? 8'h01 : 8'h00, "irq enable");
    end
    xfer(1'b1, OFS_CTRL_TWO, 8'h08);
    repeat (2) @(posedge hclk);
    chk({6'h0, txd_oe, txd_out}, 8'h03, "idle line");
    xfer(1'b1, OFS_CTRL_ONE, 8'h43);
    repeat (2) @(posedge hclk);
    chk({6'h0, txd_oe, txd_out}, 8'h00, "open drain idle");
    rd_chk(OFS_FLAGS, 8'hc0, "flags before send");
    n0 = serial_remote_inst.frames;
    xfer(1'b1, OFS_DATA_LOW, 8'h35);
    wait_frame();
    chk(serial_remote_inst.frm[7:0], 8'hb5, "odd parity frame");
    chk({7'h0, serial_remote_inst.frm[8]}, 8'h01, "stop bit");
    xfer(1'b1, OFS_CTRL_ONE, 8'h10);
    serial_remote_inst.nbits = 9;
    xfer(1'b1, OFS_DATA_HIGH, 8'h40);
    xfer(1'b0, OFS_FLAGS, 8'h00);
    n0 = serial_remote_inst.frames;
    xfer(1'b1, OFS_DATA_LOW, 8'h96);
    wait_frame();
    chk(serial_remote_inst.frm[8:1], 8'hcb, "nine bit frame");
    serial_remote_inst.nbits = 8;
    xfer(1'b1, OFS_CTRL_ONE, 8'h00);
    xfer(1'b1, OFS_CTRL_TWO, 8'h24);
    serial_remote_inst.send(9'h05a);
    poll(F_RXF);
    chk({7'h0, irq}, 8'h01, "receive irq");
    rd_chk(OFS_DATA_LOW, 8'h5a, "received data");
    repeat (2) @(posedge hclk);
    chk({7'h0, irq}, 8'h00, "receive irq cleared");
    serial_remote_inst.send(9'h011);
    serial_remote_inst.send(9'h022);
    repeat (64) @(posedge hclk);
    rd_chk(OFS_FLAGS, 8'he8, "overrun set");
    rd_chk(OFS_DATA_LOW, 8'h11, "first byte kept");
    rd_chk(OFS_FLAGS, 8'hc0, "overrun cleared");
    repeat (400) @(posedge hclk);
    rd_chk(OFS_FLAGS, 8'hd0, "quiet line");
    xfer(1'b1, OFS_CTRL_TWO, 8'h14);
    repeat (2) @(posedge hclk);
    chk({7'h0, irq}, 8'h01, "quiet irq");
    xfer(1'b0, OFS_DATA_LOW, 8'h00);
    xfer(1'b1, OFS_CTRL_TWO, 8'h00);
    serial_remote_inst.send(9'h077);
    repeat (64) @(posedge hclk);
    rd_chk(OFS_FLAGS, 8'hc0, "receiver off");
    xfer(1'b1, OFS_CTRL_ONE, 8'h80);
    xfer(1'b1, OFS_CTRL_TWO, 8'h0c);
    n0 = serial_remote_inst.frames;
    xfer(1'b1, OFS_DATA_LOW, 8'h3c);
    poll(F_RXF);
    chk({7'h0, txd_oe}, 8'h00, "loop pin released");
    rd_chk(OFS_DATA_LOW, 8'h3c, "loop data");
    chk(8'(serial_remote_inst.frames - n0), 8'h00, "loop no frame");
    xfer(1'b1, OFS_CTRL_ONE, 8'h00);
    xfer(1'b1, OFS_CTRL_TWO, 8'h08);
    xfer(1'b1, OFS_BAUD_LOW, 8'h00);
    n0 = serial_remote_inst.frames;
    xfer(1'b1, OFS_DATA_LOW, 8'h44);
    repeat (300) @(posedge hclk);
    chk(8'(serial_remote_inst.frames - n0), 8'h00, "zero divisor");
    xfer(1'b1, OFS_BAUD_LOW, 8'h01);
    wait_frame();
    chk(serial_remote_inst.frm[7:0], 8'h44, "divisor one rate");
    // Sleep with address-mark wakeup
    xfer(1'b1, OFS_CTRL_ONE, 8'h08);
    xfer(1'b1, OFS_CTRL_TWO, 8'h26);
    serial_remote_inst.send(9'h011);
    serial_remote_inst.send(9'h0a5);
    poll(F_RXF);
    rd_chk(OFS_DATA_LOW, 8'ha5, "mark wake data");
    rd_chk(OFS_CTRL_TWO, 8'h24, "sleep cleared");
    // Reset in mid-run
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk({6'h0, txd_oe, irq}, 8'h00, "pins after reset");
    rd_chk(OFS_BAUD_LOW, 8'h04, "divisor after reset");
    rd_chk(OFS_FLAGS, 8'hc0, "flags after reset");
    test_done();
  end
endmodule : testbench
`default_nettype wire
